// [design/olp_pkg.sv]
// Package: constants and state encoding for the overload protection sequencer
package olp_pkg;

	// Clock rate
	localparam int unsigned CLK_HZ           = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS    = 10;

	// Fixed overload blanking time, 20 ms
	localparam int unsigned FIXED_BLANK_MS   = 20;
	localparam int unsigned FIXED_BLANK_CYC  = FIXED_BLANK_MS * (CLK_HZ / 1000);

	// Soft start: 32 ms in 32 steps
	localparam int unsigned SOFT_START_MS    = 32;
	localparam int unsigned SOFT_START_STEPS = 32;
	localparam int unsigned SOFT_STEP_CYC    =
		(SOFT_START_MS * (CLK_HZ / 1000)) / SOFT_START_STEPS;

	// Defaults for counts the sequence leaves open
	localparam int unsigned EXT_CYCLES_DEF   = 4;
	localparam int unsigned RESTART_CYC_DEF  = 4;
	localparam int unsigned RECOVERY_US_DEF  = 2000;
	localparam int unsigned SETTLE_US_DEF    = 500;
	localparam int unsigned RECOVERY_CYC_DEF = RECOVERY_US_DEF * (CLK_HZ / 1_000_000);
	localparam int unsigned SETTLE_CYC_DEF   = SETTLE_US_DEF * (CLK_HZ / 1_000_000);

	// Width of the shared timer and the step counter
	localparam int unsigned TMR_W            = 24;
	localparam int unsigned STEP_W           = 6;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_SOFT    = 4'h0,
		ST_RUN     = 4'h1,
		ST_FB_DIS  = 4'h2,
		ST_FB_CHG  = 4'h3,
		ST_FB_ZERO = 4'h4,
		ST_FB_WAIT = 4'h5,
		ST_IS_DIS  = 4'h6,
		ST_IS_CHG  = 4'h7,
		ST_SETTLE  = 4'h8,
		ST_HOLD    = 4'h9
	} olp_state_e;

endpackage : olp_pkg

// [design/sync2.sv]
// Two flip-flop synchroniser for a group of comparator levels
`timescale 1ns/1ps
module sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,   // System clock
	input  wire logic         rst_n_i, // Active low reset
	input  wire logic [W-1:0] d_i,     // Asynchronous levels
	output logic      [W-1:0] q_o      // Synchronised levels
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	// Next values; the first stage feeds only the second
	always_comb
	begin
		meta_d = d_i;
		q_d    = meta_q;
	end

	// Both stages
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= '0;
			q_o    <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			q_o    <= q_d;
		end
	end

endmodule : sync2

// [design/overload_protection_sequencer.sv]
// Overload/open-loop fault sequencer with restart delay and soft start
`timescale 1ns/1ps

// Behaviour
// - Feedback above high threshold for the full 20 ms starts extended blanking.
// - After fixed blanking, discharge feedback to low threshold, then release it.
// - Each recharge to high threshold counts one and discharges feedback again.
// - After the set cycles, pull feedback to zero; stop when it reaches high again.
// - During extended blanking, frequency uses only minimum and current-sense currents.
// - If feedback misses high within recovery window, clear counters and resume.
// - Protection stops both gates, stays active, restarts via soft start later.
// - At protection entry discharge sense cap, then charge it; one cycle per pair.
// - Sense node at high threshold: stop charging, discharge to low threshold.
// - After restart cycles: both switches off, hysteresis source on, settle blanking.
// - After settle blanking, soft start only if sense is above mains on-threshold.
// - Soft start is 32 ms in 32 steps; overload detection suppressed meanwhile.
module overload_protection_sequencer
	import olp_pkg::*;
#(
	parameter int unsigned EXT_CYCLES   = EXT_CYCLES_DEF,
	parameter int unsigned RESTART_CYC  = RESTART_CYC_DEF,
	parameter int unsigned RECOVERY_CYC = RECOVERY_CYC_DEF,
	parameter int unsigned SETTLE_CYC   = SETTLE_CYC_DEF,
	parameter int unsigned FIXED_CYC    = FIXED_BLANK_CYC,
	parameter int unsigned SS_STEP_CYC  = SOFT_STEP_CYC
) (
	input  wire logic                  clk_i,                   // 100 MHz clock
	input  wire logic                  rst_n_i,                 // Async reset, active low
	input  wire logic                  fb_above_high_i,         // Feedback above high threshold
	input  wire logic                  fb_below_low_i,          // Feedback below low threshold
	input  wire logic                  fb_at_zero_i,            // Feedback pulled to zero
	input  wire logic                  is_above_high_i,         // Sense node above high threshold
	input  wire logic                  is_below_low_i,          // Sense node below low threshold
	input  wire logic                  is_above_mains_on_i,     // Sense above mains on-threshold
	output logic                       gate_enable_o,           // Both gates may switch
	output logic                       fb_discharge_switch_o,   // Feedback discharge switch on
	output logic                       fb_current_ignore_o,     // Drop feedback charge share
	output logic                       restart_charge_source_o, // Sense cap charge source on
	output logic                       is_discharge_switch_o,   // Sense cap discharge switch on
	output logic                       hysteresis_source_o,     // Hysteresis current source on
	output logic                       soft_start_active_o,     // Soft start running
	output logic [olp_pkg::STEP_W-1:0] soft_start_step_o,       // Soft start frequency step
	output logic                       overload_protection_o    // Protection state entered
);

	import olp_pkg::*;

	localparam logic [TMR_W-1:0]  FIXED_LAST  = TMR_W'(FIXED_CYC - 1);
	localparam logic [TMR_W-1:0]  RECOV_LAST  = TMR_W'(RECOVERY_CYC - 1);
	localparam logic [TMR_W-1:0]  SETTLE_LAST = TMR_W'(SETTLE_CYC - 1);
	localparam logic [TMR_W-1:0]  SS_LAST     = TMR_W'(SS_STEP_CYC - 1);
	localparam logic [STEP_W-1:0] SS_STEPS    = STEP_W'(SOFT_START_STEPS);
	localparam logic [7:0]        EXT_LAST    = 8'(EXT_CYCLES);
	localparam logic [7:0]        RST_LAST    = 8'(RESTART_CYC);

	logic              rst_meta_q;
	logic              rst_sync_n;
	logic [5:0]        cmp_s;
	logic              fb_hi;
	logic              fb_lo;
	logic              fb_zero;
	logic              is_hi;
	logic              is_lo;
	logic              mains_ok;

	olp_state_e        state_q;
	olp_state_e        state_d;
	logic [TMR_W-1:0]  tmr_q;
	logic [TMR_W-1:0]  tmr_d;
	logic [7:0]        cnt_q;
	logic [7:0]        cnt_d;
	logic [STEP_W-1:0] step_q;
	logic [STEP_W-1:0] step_d;

	// Reset release through two flip-flops; assertion stays asynchronous
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// Comparators are analog, so all of them are synchronised first
	sync2 #(
		.W (6)
	) u_cmp_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_sync_n),
		.d_i     ({fb_above_high_i, fb_below_low_i, fb_at_zero_i,
		           is_above_high_i, is_below_low_i, is_above_mains_on_i}),
		.q_o     (cmp_s)
	);

	assign {fb_hi, fb_lo, fb_zero, is_hi, is_lo, mains_ok} = cmp_s;

	// Sequencer next state; one shared timer serves each timed phase
	always_comb
	begin
		state_d = state_q;
		tmr_d   = tmr_q + TMR_W'(1);
		cnt_d   = cnt_q;
		step_d  = step_q;
		unique case (state_q)
			ST_SOFT:
			begin
				// Feedback is not looked at here at all
				if (tmr_q == SS_LAST)
				begin
					tmr_d  = '0;
					step_d = step_q + STEP_W'(1);
					if (step_q == SS_STEPS - STEP_W'(1))
					begin
						state_d = ST_RUN;
						step_d  = '0;
					end
				end
			end
			ST_RUN:
			begin
				// Timer only runs while feedback stays high; a dip restarts it
				if (!fb_hi)
					tmr_d = '0;
				else if (tmr_q == FIXED_LAST)
				begin
					state_d = ST_FB_DIS;
					tmr_d   = '0;
					cnt_d   = '0;
				end
			end
			ST_FB_DIS:
			begin
				if (fb_lo)
					state_d = ST_FB_CHG;
			end
			ST_FB_CHG:
			begin
				if (fb_hi)
				begin
					cnt_d = cnt_q + 8'h01;
					if (cnt_q + 8'h01 >= EXT_LAST)
						state_d = ST_FB_ZERO;
					else
						state_d = ST_FB_DIS;
				end
			end
			ST_FB_ZERO:
			begin
				tmr_d = '0;
				if (fb_zero)
					state_d = ST_FB_WAIT;
			end
			ST_FB_WAIT:
			begin
				if (fb_hi)
				begin
					state_d = ST_IS_DIS;
					cnt_d   = '0;
				end
				else if (tmr_q == RECOV_LAST)
				begin
					state_d = ST_RUN;
					tmr_d   = '0;
					cnt_d   = '0;
				end
			end
			ST_IS_DIS:
			begin
				if (is_lo)
				begin
					if (cnt_q >= RST_LAST)
					begin
						state_d = ST_SETTLE;
						tmr_d   = '0;
					end
					else
						state_d = ST_IS_CHG;
				end
			end
			ST_IS_CHG:
			begin
				if (is_hi)
				begin
					state_d = ST_IS_DIS;
					cnt_d   = cnt_q + 8'h01;
				end
			end
			ST_SETTLE:
			begin
				if (tmr_q == SETTLE_LAST)
				begin
					tmr_d = '0;
					if (mains_ok)
					begin
						state_d = ST_SOFT;
						step_d  = '0;
					end
					else
						state_d = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				// Gates stay off until mains returns above the on-threshold
				tmr_d = '0;
				if (mains_ok)
				begin
					state_d = ST_SOFT;
					step_d  = '0;
				end
			end
			default:
			begin
				state_d = ST_SOFT;
				tmr_d   = '0;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_q <= ST_SOFT;
			tmr_q   <= '0;
			cnt_q   <= '0;
			step_q  <= '0;
		end
		else
		begin
			state_q <= state_d;
			tmr_q   <= tmr_d;
			cnt_q   <= cnt_d;
			step_q  <= step_d;
		end
	end

	logic              gate_d;
	logic              fb_dis_d;
	logic              fb_ign_d;
	logic              chg_d;
	logic              is_dis_d;
	logic              hys_d;
	logic              ss_d;
	logic              olp_d;

	// Output decode from the next state, so outputs align with the state
	always_comb
	begin
		gate_d   = state_d inside {ST_SOFT, ST_RUN, ST_FB_DIS, ST_FB_CHG,
		                           ST_FB_ZERO, ST_FB_WAIT};
		fb_dis_d = state_d inside {ST_FB_DIS, ST_FB_ZERO};
		fb_ign_d = state_d inside {ST_FB_DIS, ST_FB_CHG,
		                           ST_FB_ZERO, ST_FB_WAIT};
		chg_d    = (state_d == ST_IS_CHG);
		is_dis_d = (state_d == ST_IS_DIS);
		// Hysteresis source is off only while the restart delay owns the pin
		hys_d    = !(state_d inside {ST_IS_DIS, ST_IS_CHG});
		ss_d     = (state_d == ST_SOFT);
		olp_d    = state_d inside {ST_IS_DIS, ST_IS_CHG, ST_SETTLE, ST_HOLD};
	end

	// Output registers
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			gate_enable_o           <= 1'b0;
			fb_discharge_switch_o   <= 1'b0;
			fb_current_ignore_o     <= 1'b0;
			restart_charge_source_o <= 1'b0;
			is_discharge_switch_o   <= 1'b0;
			hysteresis_source_o     <= 1'b0;
			soft_start_active_o     <= 1'b0;
			soft_start_step_o       <= '0;
			overload_protection_o   <= 1'b0;
		end
		else
		begin
			gate_enable_o           <= gate_d;
			fb_discharge_switch_o   <= fb_dis_d;
			fb_current_ignore_o     <= fb_ign_d;
			restart_charge_source_o <= chg_d;
			is_discharge_switch_o   <= is_dis_d;
			hysteresis_source_o     <= hys_d;
			soft_start_active_o     <= ss_d;
			soft_start_step_o       <= step_d;
			overload_protection_o   <= olp_d;
		end
	end

endmodule : overload_protection_sequencer

// [tb/olp_chk_properties.sv]
// Checker for the overload sequencer ports, with its bind
`timescale 1ns/1ps
module olp_chk
	import olp_pkg::*;
#(
	parameter int unsigned FIXED_CYC = 50
) (
	input wire logic              clk_i,                   // Clock
	input wire logic              rst_n_i,                 // Reset, active low
	input wire logic              fb_above_high_i,         // Feedback high
	input wire logic              is_above_high_i,         // Sense high
	input wire logic              is_below_low_i,          // Sense low
	input wire logic              gate_enable_o,           // Gates on
	input wire logic              fb_discharge_switch_o,   // Feedback switch
	input wire logic              fb_current_ignore_o,     // Feedback share off
	input wire logic              restart_charge_source_o, // Sense charge
	input wire logic              is_discharge_switch_o,   // Sense switch
	input wire logic              hysteresis_source_o,     // Hysteresis on
	input wire logic              soft_start_active_o,     // Soft start
	input wire logic [STEP_W-1:0] soft_start_step_o,       // Step
	input wire logic              overload_protection_o    // Protection
);
	logic [31:0] hi_q;
	// Run of raw feedback-high cycles; wide enough for the full-length blanking
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
			hi_q <= 32'h0;
		else
			hi_q <= !fb_above_high_i ? 32'h0 : (&hi_q ? hi_q : hi_q + 32'h1);
	// One domain, so clock and disable are given once
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_gates_off_prot: assert property (overload_protection_o |-> !gate_enable_o)
		else $error("gates enabled in protection");
	a_ignore_on_dis: assert property (fb_discharge_switch_o |-> fb_current_ignore_o)
		else $error("feedback share kept while discharging");
	a_ext_gates_on: assert property (fb_current_ignore_o |-> gate_enable_o)
		else $error("gates stopped in extended blanking");
	a_soft_no_olp: assert property (soft_start_active_o |-> !fb_discharge_switch_o
		&& !overload_protection_o)
		else $error("overload handling in soft start");
	a_blank_full: assert property ($rose(fb_current_ignore_o) |-> hi_q >= FIXED_CYC)
		else $error("extended blanking before fixed blanking ran out");
	a_dis_after_high: assert property ($rose(fb_discharge_switch_o) |-> $past(fb_above_high_i))
		else $error("feedback discharge without high level");
	a_entry_discharge: assert property ($rose(overload_protection_o) |-> is_discharge_switch_o
		&& !restart_charge_source_o)
		else $error("sense cap not discharged at entry");
	a_chg_stops_high: assert property (restart_charge_source_o && is_above_high_i
		|-> ##[1:4] !restart_charge_source_o)
		else $error("charge source kept above high level");
	a_dis_stops_low: assert property (is_discharge_switch_o && is_below_low_i
		|-> ##[1:4] !is_discharge_switch_o)
		else $error("sense discharge kept below low level");
	a_restart_hys_off: assert property (restart_charge_source_o || is_discharge_switch_o
		|-> overload_protection_o && !hysteresis_source_o)
		else $error("hysteresis on during restart delay");
	a_leave_soft: assert property ($fell(overload_protection_o) |-> soft_start_active_o
		&& gate_enable_o && soft_start_step_o == 6'h00)
		else $error("protection left without soft start");
	c_prot: cover property ($rose(overload_protection_o));
	c_last_step: cover property (soft_start_step_o == 6'h1F);
	c_settle: cover property (overload_protection_o && hysteresis_source_o);
endmodule : olp_chk

bind overload_protection_sequencer olp_chk #(.FIXED_CYC(FIXED_CYC)) chk (.*);

// [tb/cap_net_model.sv]
// Behavioural feedback and input-sense capacitor networks
`timescale 1ns/1ps
module cap_net_model (
	input  wire logic clk_i,    // Clock
	input  wire logic fault_i,  // Open loop or overload
	input  wire logic mains_i,  // Bus above on level
	input  wire logic fb_dis_i, // Feedback switch
	input  wire logic is_chg_i, // Sense charge source
	input  wire logic is_dis_i, // Sense switch
	output logic      fb_hi_o,  // Feedback high
	output logic      fb_lo_o,  // Feedback low
	output logic      fb_zero_o,// Feedback at zero
	output logic      is_hi_o,  // Sense high
	output logic      is_lo_o,  // Sense low
	output logic      is_on_o   // Sense above on level
);
	int fb_v = 40;
	int is_v = 60;
	// Nodes slew toward their target; slow discharge keeps overshoot off zero
	always @(posedge clk_i)
	begin
		fb_v <= fb_dis_i ? (fb_v > 2 ? fb_v - 2 : 0) :
			(fault_i ? (fb_v < 96 ? fb_v + 4 : 100) : (fb_v > 40 ? fb_v - 2 : fb_v + 4));
		is_v <= is_dis_i ? (is_v > 2 ? is_v - 2 : 0) :
			is_chg_i ? is_v + 2 : (is_v > (mains_i ? 60 : 20) ? is_v - 2 : is_v + 2);
	end
	// Comparator levels
	assign fb_hi_o   = fb_v >= 80;
	assign fb_lo_o   = fb_v <= 10;
	assign fb_zero_o = fb_v == 0;
	assign is_hi_o   = is_v >= 80;
	assign is_lo_o   = is_v <= 10;
	assign is_on_o   = is_v >= 50;
endmodule : cap_net_model

// [tb/tb_top.sv]
// Self-checking bench for the overload protection sequencer
`timescale 1ns/1ps
module tb_top;
	import olp_pkg::*;
	localparam int unsigned EC = 3, RC = 2, FX = 50, SS = 10, ST = 40;
	logic              clk_i = 1'b0, rst_n_i = 1'b0, fault = 1'b0, mains = 1'b1, p;
	logic              fb_hi, fb_lo, fb_zero, is_hi, is_lo, is_on;
	logic              gate, fb_dis, ign, chg, is_dis, hys, ss, prot;
	logic [STEP_W-1:0] step;
	int                err_count = 0, checked = 0, cyc = 0, n, k;
	// 100 MHz clock
	always #5 clk_i = ~clk_i;
	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			err_count++;
			final_report();
		end
	end
	// Short counts keep the run brief
	overload_protection_sequencer #(.EXT_CYCLES(EC), .RESTART_CYC(RC), .RECOVERY_CYC(40),
		.SETTLE_CYC(ST), .FIXED_CYC(FX), .SS_STEP_CYC(SS)) uut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .fb_above_high_i(fb_hi), .fb_below_low_i(fb_lo),
		.fb_at_zero_i(fb_zero), .is_above_high_i(is_hi), .is_below_low_i(is_lo),
		.is_above_mains_on_i(is_on), .gate_enable_o(gate), .fb_discharge_switch_o(fb_dis),
		.fb_current_ignore_o(ign), .restart_charge_source_o(chg),
		.is_discharge_switch_o(is_dis), .hysteresis_source_o(hys),
		.soft_start_active_o(ss), .soft_start_step_o(step), .overload_protection_o(prot));
	cap_net_model net (.clk_i(clk_i), .fault_i(fault), .mains_i(mains), .fb_dis_i(fb_dis),
		.is_chg_i(chg), .is_dis_i(is_dis), .fb_hi_o(fb_hi), .fb_lo_o(fb_lo),
		.fb_zero_o(fb_zero), .is_hi_o(is_hi), .is_lo_o(is_lo), .is_on_o(is_on));
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic final_report();
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	// Fault held through soft start must be ignored
	task automatic t_soft();
		fault = 1'b1;
		check("start", {gate, hys, step}, 8'hC0);
		p = 1'b0;
		k = 0;
		for (n = 0; n < 400 && ss === 1'b1; n++)
		begin
			@(negedge clk_i);
			p = p | fb_dis | prot;
			if (step === 6'h1F) k = 1;
		end
		check("ss len", n >= 318 && n <= 322, 1'b1);
		check("no olp", {p, k[0]}, 8'h01);
		fault = 1'b0;
	endtask : t_soft
	// Full protection pass with mains low at settle end
	task automatic fixed_overload_blanking();
		mains = 1'b0;
		// Let the node leave the high band first, so fixed blanking starts fresh
		repeat (20) @(negedge clk_i);
		fault = 1'b1;
		for (n = 0; n < 200 && fb_dis !== 1'b1; n++) @(negedge clk_i);
		check("blank", n >= 55 && n <= 70, 1'b1);
		check("ext", {ign, gate}, 8'h03);
		k = 0;
		p = 1'b1;
		for (n = 0; n < 3000 && prot !== 1'b1; n++)
		begin
			@(negedge clk_i);
			if (fb_dis && !p) k++;
			p = fb_dis;
		end
		check("ext cnt", 8'(k), 8'(EC));
		check("entry", {gate, is_dis}, 8'h01);
		fault = 1'b0;
		k = 0;
		p = 1'b0;
		for (n = 0; n < 2000 && hys !== 1'b1; n++)
		begin
			@(negedge clk_i);
			if (chg && !p) k++;
			p = chg;
		end
		check("rst cnt", 8'(k), 8'(RC));
		check("sw off", {chg, is_dis}, 8'h00);
		repeat (ST + 10) @(negedge clk_i);
		check("hold", {gate, ss, prot}, 8'h01);
		mains = 1'b1;
		for (n = 0; n < 40 && ss !== 1'b1; n++) @(negedge clk_i);
		check("restart", {gate, ss, prot}, 8'h06);
	endtask : fixed_overload_blanking
	// Fault clears during the zero discharge, so the loop recovers
	task automatic t_rec();
		for (n = 0; n < 500 && ss !== 1'b0; n++) @(negedge clk_i);
		fault = 1'b1;
		k = 0;
		p = 1'b0;
		for (n = 0; n < 3000 && k < EC + 1; n++)
		begin
			@(negedge clk_i);
			if (fb_dis && !p) k++;
			p = fb_dis;
		end
		fault = 1'b0;
		repeat (150) @(negedge clk_i);
		check("recover", {gate, ign, prot}, 8'h04);
	endtask : t_rec
	// Second protection pass with mains good, so settle ends straight in soft start
	task automatic t_settle();
		fault = 1'b1;
		for (n = 0; n < 3000 && prot !== 1'b1; n++) @(negedge clk_i);
		fault = 1'b0;
		for (n = 0; n < 2000 && hys !== 1'b1; n++) @(negedge clk_i);
		for (n = 0; n < 100 && ss !== 1'b1; n++) @(negedge clk_i);
		check("settle len", 8'(n), 8'(ST));
		check("direct", {gate, ss, prot}, 8'h06);
	endtask : t_settle
	// Main sequence
	initial
	begin
		repeat (6) @(negedge clk_i);
		rst_n_i = 1'b1;
		for (n = 0; n < 10 && ss !== 1'b1; n++) @(negedge clk_i);
		t_soft();
		fixed_overload_blanking();
		t_rec();
		t_settle();
		final_report();
	end
endmodule : tb_top
